// >>> logic/mfdt_timer.sv
// multi-function dual down-counter timer with two channel pins
// assumes a register master on clk and asynchronous channel pins
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mfdt_defines.svh"

module mfdt_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  // channel pins
  input wire logic chan_a_in,
  output logic chan_a_out,
  output logic chan_a_oe_n,
  input wire logic chan_b_in,
  // interrupt pulses
  output logic irq_chan_a,
  output logic irq_chan_b,
  output logic irq_primary_uf,
  output logic irq_secondary_uf
);

  // picks the counting tick for a clock selector
  function automatic logic sel_tick(input logic [1:0] sel, input logic presc,
                                    input logic b_edge, input logic b_lvl);
    logic t;
    t = 1'b0;
    case (mfdt_pkg::mfdt_clk_t'(sel))
      mfdt_pkg::MFDT_CLK_CPU:   t = 1'b1;
      mfdt_pkg::MFDT_CLK_PRESC: t = presc;
      mfdt_pkg::MFDT_CLK_PIN_B: t = b_edge;
      mfdt_pkg::MFDT_CLK_ACCUM: t = presc & b_lvl;
      default:                  t = 1'b0;
    endcase
    return t;
  endfunction

  logic [15:0] ctrl_q;
  logic [`MFDT_PRESC_W-1:0] presc_div_q;
  logic [`MFDT_PRESC_W-1:0] presc_cnt_q;
  logic [`MFDT_W-1:0] relcap_a_q;
  logic [`MFDT_W-1:0] relcap_b_q;
  logic [`MFDT_W-1:0] cnt1_q;
  logic [`MFDT_W-1:0] cnt2_q;
  logic [`MFDT_W-1:0] reload2_q;
  logic [3:0] irq_en_q;
  logic [3:0] irq_q;
  logic [15:0] rd_data_q;
  logic alt_q;
  logic out_a_q;
  mfdt_pkg::mfdt_pt_t pt_q;
  logic a_s1_q, a_s2_q, a_s3_q;
  logic b_s1_q, b_s2_q, b_s3_q;

  mfdt_pkg::mfdt_mode_t mode;
  logic run, presc_tick;
  logic a_rise, a_fall, b_rise, b_fall, a_edge, b_edge;
  logic wr_cnt1, wr_cnt2, wr_relcap_a, wr_relcap_b, sw_start, sw_stop;
  logic pwm_like, cap_mode, captmr, drive_a, trig_hit;
  logic act1, act2, tick1, tick2, uf1, uf2, pulse_end;
  logic cap_a, cap_b;
  logic [3:0] irq_ev;

  assign mode = mfdt_pkg::mfdt_mode_t'(ctrl_q[`MFDT_CTRL_MODE_HI:`MFDT_CTRL_MODE_LO]);
  assign run = ctrl_q[`MFDT_CTRL_RUN];
  assign pwm_like = (mode == mfdt_pkg::MFDT_MODE_PWM) || (mode == mfdt_pkg::MFDT_MODE_TRAIN);
  assign cap_mode = (mode == mfdt_pkg::MFDT_MODE_CAP);
  assign captmr = (mode == mfdt_pkg::MFDT_MODE_CAPTMR);

  // pin synchronisers, third stage only for edge detection
  // a possibly metastable first stage is never read by logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_s1_q <= 1'b0;
      a_s2_q <= 1'b0;
      a_s3_q <= 1'b0;
      b_s1_q <= 1'b0;
      b_s2_q <= 1'b0;
      b_s3_q <= 1'b0;
    end else begin
      a_s1_q <= chan_a_in;
      a_s2_q <= a_s1_q;
      a_s3_q <= a_s2_q;
      b_s1_q <= chan_b_in;
      b_s2_q <= b_s1_q;
      b_s3_q <= b_s2_q;
    end
  end

  assign a_rise = a_s2_q & ~a_s3_q;
  assign a_fall = ~a_s2_q & a_s3_q;
  assign b_rise = b_s2_q & ~b_s3_q;
  assign b_fall = ~b_s2_q & b_s3_q;
  assign a_edge = ctrl_q[`MFDT_CTRL_EDGE_A] ? a_rise : a_fall;
  assign b_edge = ctrl_q[`MFDT_CTRL_EDGE_B] ? b_rise : b_fall;

  // register strobes
  assign wr_cnt1 = wr_en && (addr == `MFDT_ADDR_CNT1);
  assign wr_cnt2 = wr_en && (addr == `MFDT_ADDR_CNT2);
  assign wr_relcap_a = wr_en && (addr == `MFDT_ADDR_RELCAP_A);
  assign wr_relcap_b = wr_en && (addr == `MFDT_ADDR_RELCAP_B);
  assign sw_start = wr_en && (addr == `MFDT_ADDR_CMD) && wr_data[`MFDT_CMD_START];
  assign sw_stop = wr_en && (addr == `MFDT_ADDR_CMD) && wr_data[`MFDT_CMD_STOP];

  // prescaler: one tick every presc_div_q+1 cycles
  // free running, so a counter started mid-period waits up to one period for its first tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt_q <= `MFDT_PRESC_ZERO;
    end else if (presc_cnt_q >= presc_div_q) begin
      presc_cnt_q <= `MFDT_PRESC_ZERO;
    end else begin
      presc_cnt_q <= presc_cnt_q + `MFDT_PRESC_ONE;
    end
  end
  assign presc_tick = (presc_cnt_q >= presc_div_q);

  // counting ticks; pin b serves as clock for either counter
  assign act1 = run && (mode != mfdt_pkg::MFDT_MODE_OFF) &&
                ((mode != mfdt_pkg::MFDT_MODE_TRAIN) || (pt_q == mfdt_pkg::MFDT_PT_RUN));
  assign tick1 = act1 && sel_tick(ctrl_q[`MFDT_CTRL_CLK1_HI:`MFDT_CTRL_CLK1_LO],
                                  presc_tick, b_edge, b_s2_q);
  assign uf1 = tick1 && (cnt1_q == `MFDT_ZERO);
  // a pulse is complete when its high phase (loaded from a) runs out;
  // counting it there leaves the pin low once the train is done, with no runt pulse
  assign pulse_end = uf1 && pwm_like && alt_q == 1'b1 && out_a_q == 1'b1;
  // one run bit serves both counters; the secondary has no enable of its own
  assign act2 = act1;
  assign tick2 = act2 && ((mode == mfdt_pkg::MFDT_MODE_TRAIN) ? pulse_end :
                 sel_tick(ctrl_q[`MFDT_CTRL_CLK2_HI:`MFDT_CTRL_CLK2_LO],
                          presc_tick, b_edge, b_s2_q));
  assign uf2 = tick2 && (cnt2_q == `MFDT_ZERO);
  assign cap_a = run && cap_mode && a_edge;
  assign cap_b = run && (cap_mode || captmr) && b_edge;

  // pulse train start trigger
  // pin b edges reach the trigger without the capture edge select
  always_comb begin
    trig_hit = 1'b0;
    case (mfdt_pkg::mfdt_trig_t'(ctrl_q[`MFDT_CTRL_TRIG_HI:`MFDT_CTRL_TRIG_LO]))
      mfdt_pkg::MFDT_TRIG_SW:   trig_hit = sw_start;
      mfdt_pkg::MFDT_TRIG_RISE: trig_hit = b_rise;
      mfdt_pkg::MFDT_TRIG_FALL: trig_hit = b_fall;
      default:                  trig_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pt_q <= mfdt_pkg::MFDT_PT_IDLE;
    end else if (sw_stop || mode != mfdt_pkg::MFDT_MODE_TRAIN || !run) begin
      pt_q <= mfdt_pkg::MFDT_PT_IDLE;
    end else begin
      case (pt_q)
        mfdt_pkg::MFDT_PT_IDLE: begin
          if (trig_hit) begin
            pt_q <= mfdt_pkg::MFDT_PT_RUN;
          end
        end
        mfdt_pkg::MFDT_PT_RUN: begin
          if (uf2) begin
            pt_q <= mfdt_pkg::MFDT_PT_DONE;
          end
        end
        mfdt_pkg::MFDT_PT_DONE: begin
          if (trig_hit) begin
            pt_q <= mfdt_pkg::MFDT_PT_RUN;
          end
        end
        default: pt_q <= mfdt_pkg::MFDT_PT_IDLE;
      endcase
    end
  end

  // primary counter
  // a software write beats everything, so a count can always be forced
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt1_q <= `MFDT_ZERO;
    end else if (wr_cnt1) begin
      cnt1_q <= wr_data;
    end else if ((cap_a && ctrl_q[`MFDT_CTRL_PRESET_A]) ||
                 (cap_mode && cap_b && ctrl_q[`MFDT_CTRL_PRESET_B])) begin
      cnt1_q <= `MFDT_ALL_ONES;
    end else if (uf1) begin
      if (pwm_like) begin
        cnt1_q <= alt_q ? relcap_b_q : relcap_a_q;
      end else if (cap_mode) begin
        cnt1_q <= `MFDT_ALL_ONES;
      end else begin
        cnt1_q <= relcap_a_q;
      end
    end else if (tick1) begin
      cnt1_q <= cnt1_q - 16'h0001;
    end
  end

  // reload order and pin a level; first reload after start is from a
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_q <= 1'b0;
      out_a_q <= 1'b0;
    end else if (!act1) begin
      alt_q <= 1'b0;
      out_a_q <= 1'b0;
    end else if (uf1) begin
      if (pwm_like) begin
        alt_q <= ~alt_q;
        out_a_q <= ~alt_q;
      end else begin
        out_a_q <= ~out_a_q;
      end
    end
  end

  // pin a drives only where the primary produces a waveform
  assign drive_a = pwm_like || mode == mfdt_pkg::MFDT_MODE_DUAL || captmr;

  // secondary counter
  // a capture preset beats the underflow reload, so the next capture measures from all ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt2_q <= `MFDT_ZERO;
    end else if (wr_cnt2) begin
      cnt2_q <= wr_data;
    end else if (captmr && cap_b && ctrl_q[`MFDT_CTRL_PRESET_B]) begin
      cnt2_q <= `MFDT_ALL_ONES;
    end else if (uf2) begin
      cnt2_q <= captmr ? `MFDT_ALL_ONES : reload2_q;
    end else if (tick2) begin
      cnt2_q <= cnt2_q - 16'h0001;
    end
  end

  // reload/capture registers; a capture beats a software write in the same cycle
  // the captured value is the count as it stood before this edge's tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relcap_a_q <= `MFDT_ZERO;
    end else if (cap_a) begin
      relcap_a_q <= cnt1_q;
    end else if (wr_relcap_a) begin
      relcap_a_q <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relcap_b_q <= `MFDT_ZERO;
    end else if (cap_b) begin
      relcap_b_q <= cap_mode ? cnt1_q : cnt2_q;
    end else if (wr_relcap_b) begin
      relcap_b_q <= wr_data;
    end
  end

  // configuration registers
  // unmapped writes fall through every branch and are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `MFDT_CTRL_RESET;
      presc_div_q <= `MFDT_PRESC_ZERO;
      reload2_q <= `MFDT_ZERO;
      irq_en_q <= 4'h0;
    end else if (wr_en) begin
      if (addr == `MFDT_ADDR_CTRL) begin
        ctrl_q <= wr_data;
      end else if (addr == `MFDT_ADDR_PRESCALE) begin
        presc_div_q <= wr_data[`MFDT_PRESC_W-1:0];
      end else if (addr == `MFDT_ADDR_RELOAD2) begin
        reload2_q <= wr_data;
      end else if (addr == `MFDT_ADDR_IRQ_EN) begin
        irq_en_q <= wr_data[3:0];
      end
    end
  end

  // interrupt sources by mode
  // pulses are registered so none can glitch; the price is one cycle of latency
  always_comb begin
    irq_ev = 4'h0;
    irq_ev[`MFDT_IRQ_D] = uf2;
    if (pwm_like) begin
      irq_ev[`MFDT_IRQ_A] = uf1;
    end else if (cap_mode) begin
      irq_ev[`MFDT_IRQ_A] = cap_a;
      irq_ev[`MFDT_IRQ_B] = cap_b;
      irq_ev[`MFDT_IRQ_C] = uf1;
    end else if (mode == mfdt_pkg::MFDT_MODE_DUAL) begin
      irq_ev[`MFDT_IRQ_A] = uf1;
    end else if (captmr) begin
      irq_ev[`MFDT_IRQ_A] = uf1;
      irq_ev[`MFDT_IRQ_B] = cap_b;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 4'h0;
    end else begin
      irq_q <= irq_ev & irq_en_q;
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  // zero outside the read cycle lets several slaves share one or-ed read bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= `MFDT_ZERO;
    end else if (!rd_en) begin
      rd_data_q <= `MFDT_ZERO;
    end else if (addr == `MFDT_ADDR_CTRL) begin
      rd_data_q <= ctrl_q;
    end else if (addr == `MFDT_ADDR_PRESCALE) begin
      rd_data_q <= {8'h00, presc_div_q};
    end else if (addr == `MFDT_ADDR_RELCAP_A) begin
      rd_data_q <= relcap_a_q;
    end else if (addr == `MFDT_ADDR_RELCAP_B) begin
      rd_data_q <= relcap_b_q;
    end else if (addr == `MFDT_ADDR_CNT1) begin
      rd_data_q <= cnt1_q;
    end else if (addr == `MFDT_ADDR_CNT2) begin
      rd_data_q <= cnt2_q;
    end else if (addr == `MFDT_ADDR_RELOAD2) begin
      rd_data_q <= reload2_q;
    end else if (addr == `MFDT_ADDR_IRQ_EN) begin
      rd_data_q <= {12'h000, irq_en_q};
    end else if (addr == `MFDT_ADDR_STATUS) begin
      rd_data_q <= {10'h000, pt_q, alt_q, out_a_q, b_s2_q, a_s2_q};
    end else begin
      rd_data_q <= `MFDT_ZERO;
    end
  end

  assign rd_data = rd_data_q;
  assign chan_a_out = out_a_q;
  assign chan_a_oe_n = ~drive_a;
  assign irq_chan_a = irq_q[`MFDT_IRQ_A];
  assign irq_chan_b = irq_q[`MFDT_IRQ_B];
  assign irq_primary_uf = irq_q[`MFDT_IRQ_C];
  assign irq_secondary_uf = irq_q[`MFDT_IRQ_D];

endmodule

`default_nettype wire

// >>> inc/mfdt_defines.svh
// register map, field positions, reset values and constants of the dual timer
// assumes a 4-bit word address and 16-bit register data
`ifndef MFDT_DEFINES_SVH
`define MFDT_DEFINES_SVH

// register indices on the plain register port
`define MFDT_ADDR_CTRL     4'h0
`define MFDT_ADDR_PRESCALE 4'h1
`define MFDT_ADDR_RELCAP_A 4'h2
`define MFDT_ADDR_RELCAP_B 4'h3
`define MFDT_ADDR_CNT1     4'h4
`define MFDT_ADDR_CNT2     4'h5
`define MFDT_ADDR_RELOAD2  4'h6
`define MFDT_ADDR_IRQ_EN   4'h7
`define MFDT_ADDR_CMD      4'h8
`define MFDT_ADDR_STATUS   4'h9

// control register fields
`define MFDT_CTRL_MODE_LO  0
`define MFDT_CTRL_MODE_HI  2
`define MFDT_CTRL_RUN      3
`define MFDT_CTRL_CLK1_LO  4
`define MFDT_CTRL_CLK1_HI  5
`define MFDT_CTRL_CLK2_LO  6
`define MFDT_CTRL_CLK2_HI  7
`define MFDT_CTRL_EDGE_A   8
`define MFDT_CTRL_EDGE_B   9
`define MFDT_CTRL_PRESET_A 10
`define MFDT_CTRL_PRESET_B 11
`define MFDT_CTRL_TRIG_LO  12
`define MFDT_CTRL_TRIG_HI  13

// command register bits, write-only
`define MFDT_CMD_START     0
`define MFDT_CMD_STOP      1

// interrupt enable bits
`define MFDT_IRQ_A         0
`define MFDT_IRQ_B         1
`define MFDT_IRQ_C         2
`define MFDT_IRQ_D         3

// widths and values
`define MFDT_W             16
`define MFDT_ZERO          16'h0000
`define MFDT_ALL_ONES      16'hffff
`define MFDT_PRESC_W       8
`define MFDT_PRESC_ZERO    8'h00
`define MFDT_PRESC_ONE     8'h01
`define MFDT_CTRL_RESET    16'h0000

`endif

// >>> inc/mfdt_pkg.sv
// types shared by the dual timer design
// assumes nothing beyond a SystemVerilog compiler
package mfdt_pkg;

  typedef enum logic [2:0] {
    MFDT_MODE_OFF    = 3'h0,
    MFDT_MODE_PWM    = 3'h1,
    MFDT_MODE_TRAIN  = 3'h2,
    MFDT_MODE_CAP    = 3'h3,
    MFDT_MODE_DUAL   = 3'h4,
    MFDT_MODE_CAPTMR = 3'h5
  } mfdt_mode_t;

  typedef enum logic [1:0] {
    MFDT_CLK_CPU   = 2'h0,
    MFDT_CLK_PRESC = 2'h1,
    MFDT_CLK_PIN_B = 2'h2,
    MFDT_CLK_ACCUM = 2'h3
  } mfdt_clk_t;

  typedef enum logic [1:0] {
    MFDT_TRIG_SW   = 2'h0,
    MFDT_TRIG_RISE = 2'h1,
    MFDT_TRIG_FALL = 2'h2
  } mfdt_trig_t;

  // gray order idle -> running -> done
  typedef enum logic [1:0] {
    MFDT_PT_IDLE = 2'b00,
    MFDT_PT_RUN  = 2'b01,
    MFDT_PT_DONE = 2'b11
  } mfdt_pt_t;

endpackage

// >>> verif/mfdt_timer_assertions.sv
// port-level assertions for the dual timer, bound into every mfdt_timer
// assumes one clock domain and the register map of mfdt_defines.svh
`timescale 1ns/1ps
`default_nettype none
`include "mfdt_defines.svh"
module mfdt_timer_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  // channel pins
  input wire logic chan_a_in,
  input wire logic chan_a_out,
  input wire logic chan_a_oe_n,
  input wire logic chan_b_in,
  // interrupt pulses
  input wire logic irq_chan_a,
  input wire logic irq_chan_b,
  input wire logic irq_primary_uf,
  input wire logic irq_secondary_uf
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadows of the control and interrupt enable registers, rebuilt from the register port
  logic [15:0] ctrl_q;
  logic [3:0] en_q;
  logic [2:0] mode;
  assign mode = ctrl_q[2:0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `MFDT_CTRL_RESET;
    end else if (wr_en && addr == `MFDT_ADDR_CTRL) begin
      ctrl_q <= wr_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 4'h0;
    end else if (wr_en && addr == `MFDT_ADDR_IRQ_EN) begin
      en_q <= wr_data[3:0];
    end
  end
  property p_oe_mode;
    chan_a_oe_n == !(mode inside {3'h1, 3'h2, 3'h4, 3'h5});
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("pin a drive enable wrong");
  property p_rd_idle;
    !$past(rd_en) |-> rd_data == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_rd_void;
    rd_en && (addr == `MFDT_ADDR_CMD || addr > `MFDT_ADDR_STATUS) |=> rd_data == 16'h0000;
  endproperty
  a_rd_void: assert property (p_rd_void) else $error("unmapped read not zero");
  property p_irq_a;
    irq_chan_a |-> en_q[0] || $past(en_q[0]);
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("channel a irq while masked");
  property p_irq_b;
    irq_chan_b |-> en_q[1] || $past(en_q[1]);
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("channel b irq while masked");
  property p_irq_c;
    irq_primary_uf |-> en_q[2] || $past(en_q[2]);
  endproperty
  a_irq_c: assert property (p_irq_c) else $error("underflow c irq while masked");
  property p_irq_d;
    irq_secondary_uf |-> en_q[3] || $past(en_q[3]);
  endproperty
  a_irq_d: assert property (p_irq_d) else $error("underflow d irq while masked");
  // a toggle caused by a control write is not an underflow, so stable control is required
  property p_dual_toggle;
    $changed(chan_a_out) && mode == 3'h4 && ctrl_q[3] && $stable(ctrl_q) && en_q[0]
      |-> irq_chan_a;
  endproperty
  a_dual_toggle: assert property (p_dual_toggle) else $error("square edge without irq");
endmodule
bind mfdt_timer mfdt_timer_chk i_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .chan_a_in(chan_a_in),
  .chan_a_out(chan_a_out), .chan_a_oe_n(chan_a_oe_n), .chan_b_in(chan_b_in),
  .irq_chan_a(irq_chan_a), .irq_chan_b(irq_chan_b), .irq_primary_uf(irq_primary_uf),
  .irq_secondary_uf(irq_secondary_uf));
`default_nettype wire

// >>> verif/mfdt_pins.sv
// far side of the channel pins: signal sources following levels the bench asks for
// assumes requested levels change right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module mfdt_pins (
  // clock
  input wire logic clk,
  // requested levels
  input wire logic lvl_a,
  input wire logic lvl_b,
  // pins
  output logic pin_a,
  output logic pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // changes land off the timer edge, as a truly asynchronous source would
  always @(posedge clk) begin
    #7;
    pin_a = lvl_a;
    pin_b = lvl_b;
  end
endmodule
`default_nettype wire

// >>> verif/multi_function_dual_timer_tb_top.sv
// self-checking bench for the dual timer: pwm, train, capture and dual modes
// assumes mfdt_timer as declared and the pin source model mfdt_pins
`timescale 1ns/1ps
`default_nettype none
`include "mfdt_defines.svh"
module multi_function_dual_timer_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  wire pin_a, pin_b, chan_a_in, chan_a_out, chan_a_oe_n;
  wire irq_a, irq_b, irq_c, irq_d;
  wire [15:0] rd_data;
  int num_errors = 0, n_compared = 0, na = 0, nb = 0, nc = 0, nd = 0, np = 0;
  int hi, lo, k, v;
  logic prev = 1'b0;
  logic [15:0] seen;
  always #25 clk = ~clk;
  // pin a is shared: the timer owns it while its enable is low
  assign chan_a_in = chan_a_oe_n ? pin_a : chan_a_out;
  mfdt_timer i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .chan_a_in(chan_a_in), .chan_a_out(chan_a_out),
    .chan_a_oe_n(chan_a_oe_n), .chan_b_in(pin_b), .irq_chan_a(irq_a), .irq_chan_b(irq_b),
    .irq_primary_uf(irq_c), .irq_secondary_uf(irq_d));
  mfdt_pins i_pins (.clk(clk), .lvl_a(lvl_a), .lvl_b(lvl_b), .pin_a(pin_a), .pin_b(pin_b));
  // event counters sampled mid-cycle, where everything has settled
  always @(negedge clk) begin
    na += (irq_a === 1'b1);
    nb += (irq_b === 1'b1);
    nc += (irq_c === 1'b1);
    nd += (irq_d === 1'b1);
    np += (chan_a_out === 1'b1 && prev === 1'b0);
    prev = chan_a_out;
  end
  task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 seen = rd_data;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic span(input logic l, output int n);
    n = 0;
    while (chan_a_out === l && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask
  // pin edges need three cycles through the synchroniser, six leave margin
  task automatic pa(input logic l);
    @(posedge clk);
    lvl_a <= l;
    cyc(6);
  endtask
  task automatic pb(input logic l);
    @(posedge clk);
    lvl_b <= l;
    cyc(6);
  endtask
  task automatic off();
    wr(`MFDT_ADDR_CTRL, `MFDT_CTRL_RESET);
    cyc(6);
  endtask
  function automatic logic [15:0] cfg(input logic [2:0] m, input logic [1:0] c1,
                                      input logic [1:0] c2, input logic [7:0] h);
    return {h, c2, c1, 1'b1, m};
  endfunction
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end
  initial begin
    v = $urandom(32'h9fbd);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk("pin a enable", 16'(chan_a_oe_n), 16'h0001);
    chk("irqs", 16'({irq_a, irq_b, irq_c, irq_d}), 16'h0000);
    rd(`MFDT_ADDR_CTRL);
    chk("ctrl", seen, `MFDT_CTRL_RESET);
    rd(4'hf);
    chk("unmapped", seen, 16'h0000);
    wr(`MFDT_ADDR_PRESCALE, 16'h0002);
    wr(`MFDT_ADDR_IRQ_EN, 16'h000f);
    for (int i = 0; i < 4; i++) begin
      int a, b, p;
      a = 1 + $urandom % 4;
      b = 1 + $urandom % 4;
      p = i[0] ? 3 : 1;
      wr(`MFDT_ADDR_RELCAP_A, 16'(a));
      wr(`MFDT_ADDR_RELCAP_B, 16'(b));
      wr(`MFDT_ADDR_CNT1, 16'h0000);
      wr(`MFDT_ADDR_CTRL, cfg(mfdt_pkg::MFDT_MODE_PWM, {1'b0, i[0]}, 2'h0, 8'h00));
      span(0, lo);
      na = 0;
      span(1, hi);
      span(0, lo);
      chk("high span", 16'(hi), 16'((a + 1) * p));
      chk("low span", 16'(lo), 16'((b + 1) * p));
      chk("reload irqs", 16'(na), 16'h0002);
      chk("pin a enable", 16'(chan_a_oe_n), 16'h0000);
      off();
    end
    v = 1 + $urandom % 5;
    wr(`MFDT_ADDR_RELCAP_A, 16'(v));
    wr(`MFDT_ADDR_RELOAD2, 16'h0003);
    wr(`MFDT_ADDR_CTRL, cfg(mfdt_pkg::MFDT_MODE_DUAL, 2'h0, 2'h0, 8'h02));
    span(0, lo);
    span(1, hi);
    span(0, lo);
    chk("square high", 16'(hi), 16'(v + 1));
    chk("square low", 16'(lo), 16'(v + 1));
    nd = 0;
    cyc(40);
    chk("secondary underflows", 16'(nd), 16'd10);
    wr(`MFDT_ADDR_CTRL, cfg(mfdt_pkg::MFDT_MODE_DUAL, 2'h0, 2'h2, 8'h02));
    wr(`MFDT_ADDR_CNT2, 16'h0003);
    nd = 0;
    repeat (4) begin
      chk("event underflow early", 16'(nd), 16'h0000);
      pb(1'b1);
      pb(1'b0);
    end
    chk("event underflow", 16'(nd), 16'h0001);
    off();
    v = $urandom % 16'hffff;
    wr(`MFDT_ADDR_CTRL, cfg(mfdt_pkg::MFDT_MODE_CAP, 2'h2, 2'h0, 8'h04));
    wr(`MFDT_ADDR_CNT1, 16'(v));
    na = 0;
    pa(1'b1);
    chk("capture on wrong edge", 16'(na), 16'h0000);
    pa(1'b0);
    rd(`MFDT_ADDR_RELCAP_A);
    chk("capture a", seen, 16'(v));
    rd(`MFDT_ADDR_CNT1);
    chk("capture preset", seen, `MFDT_ALL_ONES);
    chk("capture irq a", 16'(na), 16'h0001);
    wr(`MFDT_ADDR_CNT1, 16'h0002);
    nc = 0;
    nb = 0;
    wr(`MFDT_ADDR_CTRL, cfg(mfdt_pkg::MFDT_MODE_CAP, 2'h0, 2'h0, 8'h02));
    cyc(10);
    chk("underflow irq c", 16'(nc), 16'h0001);
    pb(1'b1);
    pb(1'b0);
    chk("capture irq b", 16'(nb), 16'h0001);
    off();
    for (int t = 0; t < 3; t++) begin
      k = $urandom % 4;
      pb(t == 2);
      wr(`MFDT_ADDR_RELCAP_A, 16'h0001);
      wr(`MFDT_ADDR_RELCAP_B, 16'h0001);
      wr(`MFDT_ADDR_CNT2, 16'(k));
      wr(`MFDT_ADDR_CNT1, 16'h0000);
      wr(`MFDT_ADDR_CTRL, cfg(mfdt_pkg::MFDT_MODE_TRAIN, 2'h0, 2'h0, 8'(t << 4)));
      np = 0;
      nd = 0;
      cyc(10);
      chk("pulses before trigger", 16'(np), 16'h0000);
      if (t == 0) begin
        wr(`MFDT_ADDR_CMD, 16'h0001);
      end else begin
        pb(t == 1);
      end
      cyc(60);
      chk("train pulses", 16'(np), 16'(k + 1));
      chk("train end irq", 16'(nd), 16'h0001);
      off();
    end
    wr(`MFDT_ADDR_CNT2, `MFDT_ALL_ONES);
    wr(`MFDT_ADDR_CTRL, cfg(mfdt_pkg::MFDT_MODE_TRAIN, 2'h0, 2'h0, 8'h00));
    np = 0;
    wr(`MFDT_ADDR_CMD, 16'h0001);
    cyc(20);
    chk("pulses before stop", 16'(np > 0), 16'h0001);
    wr(`MFDT_ADDR_CMD, 16'h0002);
    cyc(2);
    np = 0;
    cyc(20);
    chk("pulses after stop", 16'(np), 16'h0000);
    off();
    // accumulate clock stops while pin b is low, so the capture value is known
    wr(`MFDT_ADDR_PRESCALE, 16'h00ff);
    v = 1 + $urandom % 16'h7fff;
    wr(`MFDT_ADDR_RELCAP_A, 16'h0003);
    wr(`MFDT_ADDR_CTRL, cfg(mfdt_pkg::MFDT_MODE_CAPTMR, 2'h0, 2'h3, 8'h0a));
    wr(`MFDT_ADDR_CNT2, 16'(v));
    na = 0;
    nb = 0;
    pb(1'b1);
    pb(1'b0);
    rd(`MFDT_ADDR_RELCAP_B);
    chk("secondary capture", seen, 16'(v));
    rd(`MFDT_ADDR_CNT2);
    chk("secondary preset", seen | 16'h0001, `MFDT_ALL_ONES);
    chk("capture irq b", 16'(nb), 16'h0001);
    chk("timer irq a", 16'(na > 0), 16'h0001);
    wr(`MFDT_ADDR_IRQ_EN, 16'h0000);
    cyc(2);
    na = 0;
    cyc(20);
    chk("masked irq a", 16'(na), 16'h0000);
    off();
    conclude();
  end
endmodule
`default_nettype wire
